// [logic/mrt_pkg.sv]
// Package for the page-0 receive ring and transmit register slice
//
// Behaviour
// - Offset 01H holds read/write receive ring start page, reset 00h.
// - Offset 02H holds read/write receive ring stop page, reset 00h.
// - Offset 03H holds read/write boundary page pointer, reset 4Ch.
// - Offset 04H writes transmit start page, reads transmit status flags.
// - Status bit 7 flags out-of-window collision; bits 6:4, 1 reserved; reset 00h.
// - Status bit 3 set when transmission abandoned after excessive collisions.
// - Status bit 2 set when the transmission collided at least once.
// - Status bit 0 set when a packet is sent without error.
// - Offsets 05H/06H write low/high bytes of the 16-bit transmit byte count.
// - Offset 05H reads collision count in bits 3:0, upper bits zero, reset 00h.
// - No collisions leaves collided flag clear and count zero.
// - Excessive collisions set aborted flag and report count zero.
// - Collision count clears when the host sets the transmit command bit in a cycle with no report.
// - Offset 06H reads the receive backup page, reset 4Dh, buffer address 15:8.
// - Buffer logic restores its receive pointers from backup page on receive error.
// - Backup page starts as ring start page; host writes it only while held stopped.
// - Setting command bit 2 starts transmission of the described packet.
// - These registers are reachable only when page select holds 00.
package mrt_pkg;
   localparam logic [3:0] OFS_RX_START = 4'h1;
   localparam logic [3:0] OFS_RX_STOP = 4'h2;
   localparam logic [3:0] OFS_RX_LIMIT = 4'h3;
   localparam logic [3:0] OFS_TX_PAGE = 4'h4;
   localparam logic [3:0] OFS_TX_LEN_LO = 4'h5;
   localparam logic [3:0] OFS_TX_LEN_HI = 4'h6;
   localparam logic [1:0] PAGE_ZERO = 2'h0;
   localparam logic [7:0] RST_RX_START = 8'h00;
   localparam logic [7:0] RST_RX_STOP = 8'h00;
   localparam logic [7:0] RST_RX_LIMIT = 8'h4c;
   localparam logic [7:0] RST_TX_FLAGS = 8'h00;
   localparam logic [7:0] RST_RETRY = 8'h00;
   localparam logic [7:0] RST_BACKUP = 8'h4d;
   localparam logic [7:0] RST_TX_PAGE = 8'h00;
   localparam logic [15:0] RST_TX_LEN = 16'h0000;
   localparam int FLAG_LATE = 7;
   localparam int FLAG_GAVE_UP = 3;
   localparam int FLAG_COLLIDED = 2;
   localparam int FLAG_OK = 0;

   // Host bus request, one cycle strobes
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] ofs;
      logic [7:0] wdata;
   } mrt_bus_type;

   // Transmit outcome report from the MAC, one-cycle valid
   typedef struct packed {
      logic done;
      logic late;
      logic gave_up;
      logic ok;
      logic [3:0] collisions;
   } mrt_tx_report_type;
endpackage

// [logic/mrt_tx_status.sv]
// Transmit outcome flags and collision count holder
`timescale 1ns/1ps
`default_nettype none
module mrt_tx_status
   import mrt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic send_i,
   input wire mrt_tx_report_type rep_i,
   output logic [7:0] flags_o,
   output logic [3:0] count_o
);
   logic [7:0] flags_q;
   logic [3:0] count_q;
   wire logic [7:0] flags_d;
   wire logic [3:0] count_d;
   wire logic collided;

   assign collided = rep_i.collisions != 4'h0 || rep_i.gave_up;
   // Flags are per attempt: a report overwrites all of them
   assign flags_d = {rep_i.late, 3'h0, rep_i.gave_up, collided, 1'b0, rep_i.ok};
   // Excessive collisions report zero; a report beats a clear in the same cycle
   assign count_d = rep_i.gave_up ? 4'h0 : rep_i.collisions;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         flags_q <= RST_TX_FLAGS;
         count_q <= RST_RETRY[3:0];
      end
      else if (rep_i.done)
      begin
         flags_q <= flags_d;
         count_q <= count_d;
      end
      else if (send_i)
      begin
         count_q <= 4'h0;
      end
   end

   assign flags_o = flags_q;
   assign count_o = count_q;

   property p_abort_zero;
      @(posedge clk_i) disable iff (!rstn_i)
      rep_i.done && rep_i.gave_up |=> count_q == 4'h0 && flags_q[FLAG_GAVE_UP];
   endproperty
   a_abort_zero: assert property (p_abort_zero) else $error("abort count not zero");

   property p_send_clears;
      @(posedge clk_i) disable iff (!rstn_i)
      send_i && !rep_i.done |=> count_q == 4'h0;
   endproperty
   a_send_clears: assert property (p_send_clears) else $error("count not cleared");

   property p_no_col;
      @(posedge clk_i) disable iff (!rstn_i)
      rep_i.done && rep_i.collisions == 4'h0 && !rep_i.gave_up
         |=> !flags_q[FLAG_COLLIDED] && count_q == 4'h0;
   endproperty
   a_no_col: assert property (p_no_col) else $error("collided set without collisions");

   property p_reserved;
      @(posedge clk_i) disable iff (!rstn_i)
      flags_q[6:4] == 3'h0 && !flags_q[1];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status bit set");
endmodule
`default_nettype wire

// [logic/mrt_regs.sv]
// Page-0 register slice: receive ring pointers, transmit setup and status
`timescale 1ns/1ps
`default_nettype none
module mrt_regs
   import mrt_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RSTN_I,
   // Host register access, already in the clock domain
   input wire logic [1:0] PAGE_SEL_I,
   input wire mrt_bus_type BUS_I,
   output logic [7:0] RDATA_O,
   // Command and controller state
   input wire logic SEND_CMD_I,
   input wire logic HELD_STOPPED_I,
   input wire logic BACKUP_WR_I,
   input wire logic [7:0] BACKUP_WDATA_I,
   // Transmit MAC side
   input wire mrt_tx_report_type TX_REPORT_I,
   output logic TX_GO_O,
   output logic [15:0] TX_ADDR_O,
   output logic [15:0] TX_LEN_O,
   // Receive buffer management side
   input wire logic RX_NEXT_LOAD_I,
   input wire logic [7:0] RX_NEXT_PAGE_I,
   input wire logic RX_ERROR_I,
   output logic RX_RESTORE_O,
   output logic [15:0] RX_RESTORE_ADDR_O,
   output logic [15:0] RX_START_ADDR_O,
   output logic [15:0] RX_STOP_ADDR_O,
   output logic [15:0] RX_LIMIT_ADDR_O
);
   // ==========================================================
   // Register state
   logic [7:0] rx_ring_start_page_q;
   logic [7:0] rx_ring_stop_page_q;
   logic [7:0] rx_ring_read_limit_page_q;
   logic [7:0] tx_start_page_q;
   logic [7:0] tx_length_low_q;
   logic [7:0] tx_length_high_q;
   logic [7:0] rx_backup_page_q;
   logic [7:0] rdata_q;
   logic tx_go_q;
   logic rx_restore_q;
   wire logic [7:0] tx_outcome_flags;
   wire logic [3:0] tx_retry_count;

   // Page value to byte address of a 256-byte page
   function automatic logic [15:0] page_addr(input logic [7:0] page);
      page_addr = {page, 8'h00};
   endfunction

   // ==========================================================
   // Decode
   wire logic page_ok;
   wire logic wr_en;
   wire logic rd_en;
   wire logic wr_start;
   wire logic wr_stop;
   wire logic wr_limit;
   wire logic wr_tx_page;
   wire logic wr_len_lo;
   wire logic wr_len_hi;
   wire logic backup_wr_ok;
   wire logic [7:0] backup_d;
   logic [7:0] rdata_d;

   // Other pages belong to other banks; this slice stays silent there
   assign page_ok = PAGE_SEL_I == PAGE_ZERO;
   assign wr_en = BUS_I.wr && page_ok;
   assign rd_en = BUS_I.rd && page_ok;
   assign wr_start = wr_en && BUS_I.ofs == OFS_RX_START;
   assign wr_stop = wr_en && BUS_I.ofs == OFS_RX_STOP;
   assign wr_limit = wr_en && BUS_I.ofs == OFS_RX_LIMIT;
   assign wr_tx_page = wr_en && BUS_I.ofs == OFS_TX_PAGE;
   assign wr_len_lo = wr_en && BUS_I.ofs == OFS_TX_LEN_LO;
   assign wr_len_hi = wr_en && BUS_I.ofs == OFS_TX_LEN_HI;
   // Host may only rewrite the backup page while the controller is stopped
   assign backup_wr_ok = BACKUP_WR_I && HELD_STOPPED_I;
   // Ring start write also seeds the backup while stopped; host write wins,
   // buffer logic updates it while running
   assign backup_d = backup_wr_ok ? BACKUP_WDATA_I :
                     (wr_start && HELD_STOPPED_I) ? BUS_I.wdata : RX_NEXT_PAGE_I;

   always_comb
   begin
      rdata_d = 8'h00;
      unique case (BUS_I.ofs)
         OFS_RX_START: rdata_d = rx_ring_start_page_q;
         OFS_RX_STOP: rdata_d = rx_ring_stop_page_q;
         OFS_RX_LIMIT: rdata_d = rx_ring_read_limit_page_q;
         OFS_TX_PAGE: rdata_d = tx_outcome_flags;
         OFS_TX_LEN_LO: rdata_d = {4'h0, tx_retry_count};
         OFS_TX_LEN_HI: rdata_d = rx_backup_page_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // ==========================================================
   // Host-written registers
   always_ff @(posedge CLOCK_I)
   begin
      if (!RSTN_I)
      begin
         rx_ring_start_page_q <= RST_RX_START;
         rx_ring_stop_page_q <= RST_RX_STOP;
         rx_ring_read_limit_page_q <= RST_RX_LIMIT;
         tx_start_page_q <= RST_TX_PAGE;
         tx_length_low_q <= RST_TX_LEN[7:0];
         tx_length_high_q <= RST_TX_LEN[15:8];
      end
      else
      begin
         if (wr_start)
            rx_ring_start_page_q <= BUS_I.wdata;
         if (wr_stop)
            rx_ring_stop_page_q <= BUS_I.wdata;
         if (wr_limit)
            rx_ring_read_limit_page_q <= BUS_I.wdata;
         if (wr_tx_page)
            tx_start_page_q <= BUS_I.wdata;
         if (wr_len_lo)
            tx_length_low_q <= BUS_I.wdata;
         if (wr_len_hi)
            tx_length_high_q <= BUS_I.wdata;
      end
   end

   // Backup page register and receive restore strobe
   always_ff @(posedge CLOCK_I)
   begin
      if (!RSTN_I)
      begin
         rx_backup_page_q <= RST_BACKUP;
         rx_restore_q <= 1'b0;
      end
      else
      begin
         if (backup_wr_ok || (wr_start && HELD_STOPPED_I) || RX_NEXT_LOAD_I)
            rx_backup_page_q <= backup_d;
         rx_restore_q <= RX_ERROR_I;
      end
   end

   // Read data and transmit launch
   always_ff @(posedge CLOCK_I)
   begin
      if (!RSTN_I)
      begin
         rdata_q <= 8'h00;
         tx_go_q <= 1'b0;
      end
      else
      begin
         if (rd_en)
            rdata_q <= rdata_d;
         tx_go_q <= SEND_CMD_I;
      end
   end

   // ==========================================================
   // Transmit status
   mrt_tx_status u_status (
      .clk_i(CLOCK_I),
      .rstn_i(RSTN_I),
      .send_i(SEND_CMD_I),
      .rep_i(TX_REPORT_I),
      .flags_o(tx_outcome_flags),
      .count_o(tx_retry_count)
   );

   // ==========================================================
   // Outputs; addresses are combinational off flops through a fixed shift
   assign RDATA_O = rdata_q;
   assign TX_GO_O = tx_go_q;
   assign TX_ADDR_O = page_addr(tx_start_page_q);
   assign TX_LEN_O = {tx_length_high_q, tx_length_low_q};
   assign RX_RESTORE_O = rx_restore_q;
   assign RX_RESTORE_ADDR_O = page_addr(rx_backup_page_q);
   assign RX_START_ADDR_O = page_addr(rx_ring_start_page_q);
   assign RX_STOP_ADDR_O = page_addr(rx_ring_stop_page_q);
   assign RX_LIMIT_ADDR_O = page_addr(rx_ring_read_limit_page_q);

   // ==========================================================
   // Checks
   sequence s_len_written;
      wr_len_lo ##1 wr_len_hi;
   endsequence

   property p_len;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      s_len_written |=> TX_LEN_O == {$past(BUS_I.wdata), $past(BUS_I.wdata, 2)};
   endproperty
   a_len: assert property (p_len) else $error("byte count pairing wrong");

   property p_page_gate;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      BUS_I.wr && PAGE_SEL_I != PAGE_ZERO |=> $stable(rx_ring_start_page_q)
         && $stable(rx_ring_stop_page_q) && $stable(rx_ring_read_limit_page_q);
   endproperty
   a_page_gate: assert property (p_page_gate) else $error("write on wrong page");

   property p_read_flags;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      rd_en && BUS_I.ofs == OFS_TX_PAGE |=> RDATA_O == $past(tx_outcome_flags);
   endproperty
   a_read_flags: assert property (p_read_flags) else $error("status read wrong");

   property p_read_count;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      rd_en && BUS_I.ofs == OFS_TX_LEN_LO |=> RDATA_O[7:4] == 4'h0;
   endproperty
   a_read_count: assert property (p_read_count) else $error("count upper bits set");

   property p_backup_guard;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      BACKUP_WR_I && !HELD_STOPPED_I && !RX_NEXT_LOAD_I |=> $stable(rx_backup_page_q);
   endproperty
   a_backup_guard: assert property (p_backup_guard) else $error("backup written while running");

   property p_restore;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      RX_ERROR_I |=> RX_RESTORE_O && RX_RESTORE_ADDR_O[15:8] == rx_backup_page_q;
   endproperty
   a_restore: assert property (p_restore) else $error("restore missed");

   property p_go;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      SEND_CMD_I |=> TX_GO_O && TX_ADDR_O == {tx_start_page_q, 8'h00};
   endproperty
   a_go: assert property (p_go) else $error("transmit start missed");
endmodule
`default_nettype wire

// [tb/mrt_mac_model.sv]
// Transmit MAC stand-in that answers a start pulse with a commanded outcome report
`timescale 1ns/1ps
`default_nettype none
module mrt_mac_model
   import mrt_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Start request and commanded outcome
   input wire logic go_i,
   input wire logic [7:0] delay_i,
   input wire mrt_tx_report_type out_i,
   // Outcome report
   output mrt_tx_report_type rep_o
);
   logic [7:0] cnt_q;
   logic done_q;
   // ==========================================
   // Frame timer
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         cnt_q <= 8'h00;
      else if (go_i)
         cnt_q <= delay_i;
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
      done_q <= rstn_i && (cnt_q == 8'h01);
   end
   // Between reports the fields carry garbage, so a design that samples them late sees it
   assign rep_o = done_q ? {1'b1, out_i[6:0]} : {1'b0, ~out_i[6:0]};
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the page-0 register slice
`timescale 1ns/1ps
`default_nettype none
module tb
   import mrt_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] page = 2'h0;
   mrt_bus_type bus = '0;
   logic send = 1'b0, held = 1'b0, bwr = 1'b0, rx_load = 1'b0, rx_err = 1'b0;
   logic [7:0] bdata = 8'h00, rx_page = 8'h00, dly = 8'h03;
   mrt_tx_report_type cfg = '0, rep;
   logic [7:0] rdata;
   logic go, restore;
   logic [15:0] tx_addr, tx_len, rs_addr, st_addr, sp_addr, lm_addr;
   int errors = 0, num_checks = 0, cycles = 0;

   mrt_regs u_dut (.CLOCK_I(clk), .RSTN_I(rstn), .PAGE_SEL_I(page), .BUS_I(bus),
      .RDATA_O(rdata), .SEND_CMD_I(send), .HELD_STOPPED_I(held), .BACKUP_WR_I(bwr),
      .BACKUP_WDATA_I(bdata), .TX_REPORT_I(rep), .TX_GO_O(go), .TX_ADDR_O(tx_addr),
      .TX_LEN_O(tx_len), .RX_NEXT_LOAD_I(rx_load), .RX_NEXT_PAGE_I(rx_page),
      .RX_ERROR_I(rx_err), .RX_RESTORE_O(restore), .RX_RESTORE_ADDR_O(rs_addr),
      .RX_START_ADDR_O(st_addr), .RX_STOP_ADDR_O(sp_addr), .RX_LIMIT_ADDR_O(lm_addr));
   mrt_mac_model u_mac (.clk_i(clk), .rstn_i(rstn), .go_i(go), .delay_i(dly), .out_i(cfg),
      .rep_o(rep));

   // ==========================================
   // Clock, watchdog and verdict
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // ==========================================
   // Host bus cycles: request held one edge, read data sampled the cycle after
   task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
      @(negedge clk);
      bus = '{1'b0, 1'b1, ofs, d};
      @(negedge clk);
      bus = '0;
   endtask
   // Length bytes low then high on adjacent cycles, so the pairing check sees both
   task automatic wr_len(input logic [15:0] len);
      @(negedge clk);
      bus = '{1'b0, 1'b1, OFS_TX_LEN_LO, len[7:0]};
      @(negedge clk);
      bus = '{1'b0, 1'b1, OFS_TX_LEN_HI, len[15:8]};
      @(negedge clk);
      bus = '0;
   endtask
   task automatic rd(input logic [3:0] ofs, input logic [7:0] exp);
      @(negedge clk);
      bus = '{1'b1, 1'b0, ofs, 8'h00};
      @(negedge clk);
      bus = '0;
      chk("rdata", {8'h00, rdata}, {8'h00, exp});
   endtask
   // Start a frame, wait for the MAC report, then read flags and count
   task automatic send_tx(input logic [7:0] d, input logic [7:0] o, input logic [7:0] fl,
      input logic [7:0] nc, input logic early);
      dly = d;
      cfg = o;
      @(negedge clk);
      send = 1'b1;
      @(negedge clk);
      send = 1'b0;
      chk("tx_go", {15'h0000, go}, 16'h0001);
      if (early)
         rd(OFS_TX_LEN_LO, 8'h00);
      for (int i = 0; i < 300 && rep.done !== 1'b1; i++)
         @(negedge clk);
      rd(OFS_TX_PAGE, fl);
      rd(OFS_TX_LEN_LO, nc);
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h4c);
      rd(4'h4, 8'h00);
      rd(4'h5, 8'h00);
      rd(4'h6, 8'h4d);
      rd(4'h0, 8'h00);
      rd(4'hf, 8'h00);
      chk("limit_addr", lm_addr, 16'h4c00);
      wr(4'h1, 8'h41);
      wr(4'h2, 8'h7f);
      wr(4'h3, 8'h42);
      rd(4'h1, 8'h41);
      rd(4'h2, 8'h7f);
      rd(4'h3, 8'h42);
      chk("start_addr", st_addr, 16'h4100);
      chk("stop_addr", sp_addr, 16'h7f00);
      rd(4'h6, 8'h4d);
      page = 2'h1;
      wr(4'h1, 8'hee);
      page = 2'h3;
      wr(4'h2, 8'hee);
      page = 2'h0;
      rd(4'h1, 8'h41);
      rd(4'h2, 8'h7f);
      wr(4'h6, 8'h12);
      wr(4'h5, 8'h34);
      wr(4'h4, 8'h46);
      chk("tx_len", tx_len, 16'h1234);
      chk("tx_addr", tx_addr, 16'h4600);
      wr_len(16'h05dc);
      chk("tx_len", tx_len, 16'h05dc);
      rd(4'h4, 8'h00);
      rd(4'h6, 8'h4d);
      send_tx(8'h03, 8'h10, 8'h01, 8'h00, 1'b0);
      send_tx(8'h05, 8'h13, 8'h05, 8'h03, 1'b0);
      send_tx(8'h14, 8'h42, 8'h84, 8'h02, 1'b1);
      send_tx(8'h04, 8'h2f, 8'h0c, 8'h00, 1'b0);
      held = 1'b1;
      bwr = 1'b1;
      bdata = 8'h60;
      @(negedge clk);
      bwr = 1'b0;
      rd(4'h6, 8'h60);
      wr(4'h1, 8'h48);
      rd(4'h6, 8'h48);
      held = 1'b0;
      bwr = 1'b1;
      bdata = 8'h77;
      @(negedge clk);
      bwr = 1'b0;
      rd(4'h6, 8'h48);
      rx_load = 1'b1;
      rx_page = 8'h55;
      @(negedge clk);
      rx_load = 1'b0;
      rd(4'h6, 8'h55);
      rx_err = 1'b1;
      @(negedge clk);
      rx_err = 1'b0;
      chk("restore", {15'h0000, restore}, 16'h0001);
      chk("restore_addr", rs_addr, 16'h5500);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      rd(4'h3, 8'h4c);
      rd(4'h6, 8'h4d);
      chk("tx_len", tx_len, 16'h0000);
      stop_test();
   end
endmodule
`default_nettype wire
